// file: rtl/sync_serial_consts.vh
// Register offsets, field positions and reset values of the synchronous serial channel
`ifndef SYNC_SERIAL_CONSTS_VH
`define SYNC_SERIAL_CONSTS_VH

`define MODE_REG_ADDR      12'h000
`define DIVIDER_ADDR       12'h004
`define CTRL_ZERO_ADDR     12'h008
`define CTRL_ONE_ADDR      12'h00c
`define TX_BUF_ADDR        12'h010
`define RX_BUF_ADDR        12'h014
`define STATUS_ADDR        12'h018

`define MODE_CLK_SRC_BIT   0
`define C0_PRESCALE_LO     0
`define C0_PRESCALE_HI     1
`define C0_HS_SELECT_BIT   2
`define C0_HS_DISABLE_BIT  3
`define C0_OPEN_DRAIN_BIT  4
`define C0_POLARITY_BIT    5
`define C0_MSB_FIRST_BIT   6
`define C1_TX_EN_BIT       0
`define C1_RX_EN_BIT       1
`define C1_IRQ_SRC_BIT     2
`define C1_CONT_RX_BIT     3
`define C1_INVERT_BIT      4
`define C1_CLK_PIN_SEL_BIT 5
`define C1_SPLIT_HS_BIT    6

`define ST_TXBE_BIT        0
`define ST_TXEMPTY_BIT     1
`define ST_RX_FULL_BIT     2
`define ST_OVERRUN_BIT     3

`define MODE_RESET         8'h00
`define DIVIDER_RESET      8'h00
`define CTRL_ZERO_RESET    8'h08
`define CTRL_ONE_RESET     8'h00

`define WORD_BITS          4'h8
`define OVERRUN_BIT_COUNT  4'h7

`endif

// file: rtl/bit_rate_gen.v
// Prescaler and 8-bit divider that produce the internal transfer clock edge ticks
`timescale 1ns/10ps
`include "sync_serial_consts.vh"

module bit_rate_gen (
	input  wire       clk,
	input  wire       rst,
	input  wire       run,
	input  wire [1:0] prescale_sel,
	input  wire [7:0] bit_rate_divider,
	output reg        half_tick_q
);

	reg [4:0] pre_cnt_q;
	reg [7:0] div_cnt_q;
	reg       pre_tick;

	// Prescaled source: divide by 1, 2, 8 or 32 of clk
	always @* begin
		case (prescale_sel)
			2'h0: pre_tick = 1'b1;
			2'h1: pre_tick = (pre_cnt_q[0] == 1'b1);
			2'h2: pre_tick = (pre_cnt_q[2:0] == 3'h7);
			default: pre_tick = (pre_cnt_q == 5'h1f);
		endcase
	end

	// Half period is n+1 prescaled ticks, so period is 2(n+1)
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_cnt_q   <= 5'h00;
			div_cnt_q   <= 8'h00;
			half_tick_q <= 1'b0;
		end else if (!run) begin
			pre_cnt_q   <= 5'h00;
			div_cnt_q   <= 8'h00;
			half_tick_q <= 1'b0;
		end else begin
			pre_cnt_q   <= pre_cnt_q + 5'h01;
			half_tick_q <= 1'b0;
			if (pre_tick) begin
				if (div_cnt_q == bit_rate_divider) begin
					div_cnt_q   <= 8'h00;
					half_tick_q <= 1'b1;
				end else begin
					div_cnt_q <= div_cnt_q + 8'h01;
				end
			end
		end
	end

endmodule

// file: rtl/sync_serial.v
// Clock synchronous serial channel with APB register access
// Summary of operation
// - Each word is exactly eight bits in both directions.
// - Internal clock is prescaled source divided by 2(n+1), n 00h..FFh.
// - Clock source select 1 takes the transfer clock from the clock pin.
// - Software picks clear-to-send gating, request-to-send output, or none.
// - Transmit starts only with transmit enable set and a word buffered.
// - With clear-to-send gating, transmit waits for the input low.
// - Reception needs receive enable, transmit enable and a buffered word, unless continuous receive is armed.
// - Irq source 0: transmit interrupt when buffer moves to shift register.
// - Irq source 1: transmit interrupt when whole word has been sent.
// - Receive interrupt when finished word moves to the receive buffer.
// - Overrun set at seventh bit of new word with buffer unread.
// - Clock polarity picks which transfer clock edge outputs and samples.
// - Bit order picks LSB first or MSB first.
// - Continuous receive: reading receive buffer enables the next reception.
// - Inversion flips every transmitted and received bit.
// - Transfer clock may go to either of two clock output pins.
// - Clear-to-send and request-to-send can use separate pins.
// - On overrun the buffer is undefined and no receive interrupt.
// - Data output idles high, or released when open drain.
// - Polarity 0: output on falling edge, sample on rising; 1 swaps.
`timescale 1ns/10ps
`include "sync_serial_consts.vh"

module sync_serial (
	input  wire        clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        serial_clock_pin_in,
	output reg         serial_clock_pin_out,
	output reg         serial_clock_pin_oe,
	output reg         serial_clock_alt_out,
	output reg         serial_clock_alt_oe,
	input  wire        serial_data_in,
	output reg         serial_data_out,
	output reg         serial_data_oe,
	input  wire        clear_to_send_pin,
	input  wire        clear_to_send_alt_pin,
	output reg         request_to_send_pin,
	output reg         request_to_send_alt_pin,
	output reg         tx_irq,
	output reg         rx_irq
);

	localparam [2:0] S_IDLE  = 3'b001;
	localparam [2:0] S_SHIFT = 3'b010;
	localparam [2:0] S_DONE  = 3'b100;

	reg  [7:0] channel_mode_reg_q;
	reg  [7:0] bit_rate_divider_q;
	reg  [7:0] channel_control_zero_q;
	reg  [7:0] channel_control_one_q;
	reg  [7:0] tx_buffer_q;
	reg  [7:0] rx_buffer_q;
	reg  [7:0] tx_shift_q;
	reg  [7:0] rx_shift_q;
	reg  [3:0] bit_cnt_q;
	reg  [2:0] state_q;
	reg        tx_buffer_empty_flag_q;
	reg        tx_empty_q;
	reg        rx_full_q;
	reg        overrun_flag_q;
	reg        rx_armed_q;
	reg        sclk_q;
	reg        ext_clk_prev_q;
	reg        out_bit_q;
	reg        rx_take_q;

	wire       ext_clk = channel_mode_reg_q[`MODE_CLK_SRC_BIT];
	wire       polarity = channel_control_zero_q[`C0_POLARITY_BIT];
	wire       msb_first = channel_control_zero_q[`C0_MSB_FIRST_BIT];
	wire       hs_off = channel_control_zero_q[`C0_HS_DISABLE_BIT];
	wire       hs_rts = channel_control_zero_q[`C0_HS_SELECT_BIT];
	wire       open_drain = channel_control_zero_q[`C0_OPEN_DRAIN_BIT];
	wire       transmit_enable = channel_control_one_q[`C1_TX_EN_BIT];
	wire       rx_enable = channel_control_one_q[`C1_RX_EN_BIT];
	wire       tx_irq_source_select = channel_control_one_q[`C1_IRQ_SRC_BIT];
	wire       continuous_rx_mode = channel_control_one_q[`C1_CONT_RX_BIT];
	wire       invert = channel_control_one_q[`C1_INVERT_BIT];
	wire       clk_pin_sel = channel_control_one_q[`C1_CLK_PIN_SEL_BIT];
	wire       split_hs = channel_control_one_q[`C1_SPLIT_HS_BIT];
	wire       half_tick;

	wire       apb_access = psel && penable && pready;
	wire       apb_wr = apb_access && pwrite;
	wire       apb_rd = apb_access && !pwrite;
	wire       rx_read = apb_rd && (paddr == `RX_BUF_ADDR);
	wire       tx_write = apb_wr && (paddr == `TX_BUF_ADDR);

	// Selected clear-to-send input; split pins route it from the alternate pin
	wire       cts_in = split_hs ? clear_to_send_alt_pin : clear_to_send_pin;
	wire       cts_ok = hs_off || hs_rts || !cts_in;
	wire       start_ok = transmit_enable && !tx_buffer_empty_flag_q && cts_ok;
	wire       rx_start = rx_enable && transmit_enable;

	// Edges of the transfer clock: internal ticks toggle sclk, external edges observed
	wire       ext_rise = ext_clk && serial_clock_pin_in && !ext_clk_prev_q;
	wire       ext_fall = ext_clk && !serial_clock_pin_in && ext_clk_prev_q;
	// First toggle away from the idle level is the leading edge
	wire       int_lead = !ext_clk && half_tick && (sclk_q != polarity);
	wire       int_trail = !ext_clk && half_tick && (sclk_q == polarity);
	// Leading edge is falling for polarity 0: output changes there
	wire       lead_edge = int_lead || (polarity ? ext_rise : ext_fall);
	wire       trail_edge = int_trail || (polarity ? ext_fall : ext_rise);
	wire       rx_bit = serial_data_in ^ invert;
	wire [7:0] rx_next = msb_first ? {rx_shift_q[6:0], rx_bit} : {rx_bit, rx_shift_q[7:1]};

	function [7:0] reg_read;
		input [11:0] addr;
		begin
			case (addr)
				`MODE_REG_ADDR:  reg_read = channel_mode_reg_q;
				`DIVIDER_ADDR:   reg_read = bit_rate_divider_q;
				`CTRL_ZERO_ADDR: reg_read = channel_control_zero_q;
				`CTRL_ONE_ADDR:  reg_read = channel_control_one_q;
				`TX_BUF_ADDR:    reg_read = tx_buffer_q;
				`RX_BUF_ADDR:    reg_read = rx_buffer_q;
				`STATUS_ADDR:    reg_read = {4'h0, overrun_flag_q, rx_full_q,
						tx_empty_q, tx_buffer_empty_flag_q};
				default:         reg_read = 8'h00;
			endcase
		end
	endfunction

	function addr_valid;
		input [11:0] addr;
		begin
			addr_valid = (addr <= `STATUS_ADDR) && (addr[1:0] == 2'h0);
		end
	endfunction

	bit_rate_gen u_brg (
		.clk              (clk),
		.rst              (rst),
		.run              (state_q == S_SHIFT),
		.prescale_sel     (channel_control_zero_q[`C0_PRESCALE_HI:`C0_PRESCALE_LO]),
		.bit_rate_divider (bit_rate_divider_q),
		.half_tick_q      (half_tick)
	);

	// APB slave: one wait state so every access answers on the second access cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_valid(paddr);
			if (psel && penable && !pready && !pwrite)
				prdata <= {24'h000000, reg_read(paddr)};
		end
	end

	// Configuration registers
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			channel_mode_reg_q     <= `MODE_RESET;
			bit_rate_divider_q     <= `DIVIDER_RESET;
			channel_control_zero_q <= `CTRL_ZERO_RESET;
			channel_control_one_q  <= `CTRL_ONE_RESET;
			tx_buffer_q            <= 8'h00;
		end else if (apb_wr) begin
			case (paddr)
				`MODE_REG_ADDR:  channel_mode_reg_q <= pwdata[7:0];
				`DIVIDER_ADDR:   bit_rate_divider_q <= pwdata[7:0];
				`CTRL_ZERO_ADDR: channel_control_zero_q <= pwdata[7:0];
				`CTRL_ONE_ADDR:  channel_control_one_q <= pwdata[7:0];
				`TX_BUF_ADDR:    tx_buffer_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Transfer engine
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q                <= S_IDLE;
			tx_buffer_empty_flag_q <= 1'b1;
			tx_empty_q             <= 1'b1;
			rx_full_q              <= 1'b0;
			overrun_flag_q         <= 1'b0;
			rx_armed_q             <= 1'b0;
			tx_shift_q             <= 8'h00;
			rx_shift_q             <= 8'h00;
			rx_buffer_q            <= 8'h00;
			bit_cnt_q              <= 4'h0;
			sclk_q                 <= 1'b1;
			ext_clk_prev_q         <= 1'b1;
			out_bit_q              <= 1'b1;
			rx_take_q              <= 1'b0;
			tx_irq                 <= 1'b0;
			rx_irq                 <= 1'b0;
		end else begin
			ext_clk_prev_q <= serial_clock_pin_in;
			// Sample one clock after the internal edge, when the pin shows it
			rx_take_q <= (state_q == S_SHIFT) && trail_edge;
			if (rx_take_q)
				rx_shift_q <= rx_next;
			tx_irq <= 1'b0;
			rx_irq <= 1'b0;
			if (rx_read) begin
				rx_full_q <= 1'b0;
				if (continuous_rx_mode)
					rx_armed_q <= 1'b1;
			end
			if (tx_write)
				tx_buffer_empty_flag_q <= 1'b0;
			case (state_q)
				S_IDLE: begin
					sclk_q <= ~polarity;
					if (start_ok || (continuous_rx_mode && rx_armed_q && rx_start)) begin
						if (start_ok) begin
							tx_shift_q             <= tx_buffer_q;
							tx_buffer_empty_flag_q <= tx_write ? 1'b0 : 1'b1;
							tx_irq                 <= !tx_irq_source_select;
						end else begin
							tx_shift_q <= 8'hff;
						end
						rx_armed_q <= 1'b0;
						tx_empty_q <= 1'b0;
						bit_cnt_q  <= 4'h0;
						state_q    <= S_SHIFT;
					end
				end
				S_SHIFT: begin
					if (half_tick)
						sclk_q <= ~sclk_q;
					if (lead_edge) begin
						out_bit_q  <= (msb_first ? tx_shift_q[7] : tx_shift_q[0]) ^ invert;
						tx_shift_q <= msb_first ? {tx_shift_q[6:0], 1'b0} : {1'b0, tx_shift_q[7:1]};
					end
					if (trail_edge) begin
						bit_cnt_q  <= bit_cnt_q + 4'h1;
						if (rx_start && rx_full_q && bit_cnt_q + 4'h1 == `OVERRUN_BIT_COUNT)
							overrun_flag_q <= 1'b1;
						if (bit_cnt_q + 4'h1 == `WORD_BITS)
							state_q <= S_DONE;
					end
				end
				S_DONE: begin
					tx_empty_q <= 1'b1;
					tx_irq     <= tx_irq_source_select;
					if (rx_start && !overrun_flag_q) begin
						// Last bit is taken in this cycle, so it bypasses the shifter
						rx_buffer_q <= rx_next;
						rx_full_q   <= 1'b1;
						rx_irq      <= 1'b1;
					end
					// Buffer is left as is on overrun and no receive interrupt fires
					if (rx_start && overrun_flag_q)
						rx_full_q <= 1'b1;
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
			// Overrun clears when the status register is read, except in a cycle with a trailing edge while shifting
			if (apb_rd && paddr == `STATUS_ADDR && !(state_q == S_SHIFT && trail_edge))
				overrun_flag_q <= 1'b0;
		end
	end

	// Pin drive, all from flip-flops
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			serial_clock_pin_out    <= 1'b1;
			serial_clock_pin_oe     <= 1'b0;
			serial_clock_alt_out    <= 1'b1;
			serial_clock_alt_oe     <= 1'b0;
			serial_data_out         <= 1'b1;
			serial_data_oe          <= 1'b0;
			request_to_send_pin     <= 1'b1;
			request_to_send_alt_pin <= 1'b1;
		end else begin
			serial_clock_pin_out <= sclk_q;
			serial_clock_pin_oe  <= !ext_clk && !clk_pin_sel;
			serial_clock_alt_out <= sclk_q;
			serial_clock_alt_oe  <= !ext_clk && clk_pin_sel;
			// Idle high; open drain releases the line for a one
			serial_data_out      <= (state_q == S_IDLE) ? 1'b1 : out_bit_q;
			serial_data_oe       <= open_drain ?
				!((state_q == S_IDLE) || out_bit_q) : 1'b1;
			// Request-to-send low while ready to receive
			if (!hs_off && hs_rts) begin
				request_to_send_pin     <= !(rx_enable && !rx_full_q && state_q == S_IDLE);
				request_to_send_alt_pin <= split_hs ?
					!(rx_enable && !rx_full_q && state_q == S_IDLE) : 1'b1;
			end else begin
				request_to_send_pin     <= 1'b1;
				request_to_send_alt_pin <= 1'b1;
			end
		end
	end

endmodule

// file: sim/serial_chk.sv
// Port-level assertions for the synchronous serial channel
`timescale 1ns/10ps
module serial_chk (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        serial_clock_pin_oe,
	input wire logic        serial_clock_alt_oe,
	input wire logic        tx_irq,
	input wire logic        rx_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_READY_PULSE:
		assert property (pready |=> !pready) else $error("pready held too long");
	AST_READY_WAIT:
		assert property ($rose(penable) && psel |=> pready) else $error("pready late");
	AST_READY_ACCESS:
		assert property (pready |-> psel && penable) else $error("pready outside access");
	AST_ERR_READY:
		assert property (pslverr |-> pready) else $error("pslverr without pready");
	AST_ERR_ZERO:
		assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
			else $error("refused read not zero");
	AST_BYTE_WIDE:
		assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
			else $error("upper read bits set");
	AST_TXIRQ_PULSE:
		assert property (tx_irq |=> !tx_irq) else $error("tx_irq too long");
	AST_RXIRQ_GAP:
		assert property (rx_irq |=> (!rx_irq)[*8]) else $error("rx_irq too soon");
	AST_ONE_CLK_PIN:
		assert property (!(serial_clock_pin_oe && serial_clock_alt_oe))
			else $error("both clock pins driven");
endmodule
bind sync_serial serial_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.serial_clock_pin_oe(serial_clock_pin_oe), .serial_clock_alt_oe(serial_clock_alt_oe),
	.tx_irq(tx_irq), .rx_irq(rx_irq));

// file: sim/serial_peer.sv
// Far-side serial peripheral clocked by the channel's transfer clock
`timescale 1ns/10ps
module serial_peer (
	input  wire logic       sclk,
	input  wire logic       pol,
	input  wire logic       sdo,
	input  wire logic       ld,
	input  wire logic [7:0] word,
	output logic            sdi,
	output logic [7:0]      got
);
	logic [7:0] sh = 8'h00;
	wire        lead = sclk ^ pol;
	initial sdi = 1'b0;
	always @(ld) sh = word;
	// Drive on the leading edge, MSB first; refill with complements so stale bits change
	always @(negedge lead) begin
		sdi <= sh[7];
		sh <= {sh[6:0], ~sh[7]};
	end
	always @(posedge lead) got <= {got[6:0], sdo};
endmodule

// file: sim/sync_serial_tb.sv
// Self-checking bench for the synchronous serial channel
`timescale 1ns/10ps
`include "sync_serial_consts.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module sync_serial_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, sck, sck_oe, sdi, sdo, txi, rxi;
	logic        cts = 1'b1;
	logic        pol = 1'b0;
	logic        ld = 1'b0;
	logic        ext = 1'b0;
	logic        esck = 1'b1;
	logic [7:0]  pw = 8'h00;
	logic [7:0]  got;
	int          failures = 0, comparisons = 0, ntx, nrx, nact;

	always #20 clk = ~clk;

	sync_serial u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_clock_pin_in(esck), .serial_clock_pin_out(sck), .serial_clock_pin_oe(sck_oe),
		.serial_clock_alt_out(), .serial_clock_alt_oe(), .serial_data_in(sdi),
		.serial_data_out(sdo), .serial_data_oe(), .clear_to_send_pin(cts),
		.clear_to_send_alt_pin(1'b1), .request_to_send_pin(), .request_to_send_alt_pin(),
		.tx_irq(txi), .rx_irq(rxi));
	serial_peer u_peer (.sclk(ext ? esck : sck), .pol(pol), .sdo(sdo), .ld(ld), .word(pw), .sdi(sdi),
		.got(got));

	// Active half-periods are those away from the idle level
	always @(posedge clk) begin
		ntx += txi;
		nrx += rxi;
		nact += (sck_oe === 1'b1 && sck === pol);
	end

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		// Waits for pready with no limit of its own; only the watchdog ends a hung access
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask
	task automatic wt(ref int c, input int v);
		int k;
		k = 0;
		while (c < v && k < 3000) begin
			@(negedge clk);
			k++;
		end
		if (k == 3000) failures++;
	endtask
	function automatic logic [7:0] expb(input logic [7:0] b, input logic m, input logic v);
		logic [7:0] r;
		for (int j = 0; j < 8; j++) r[j] = m ? b[j] : b[7 - j];
		return r ^ {8{v}};
	endfunction
	task tally_and_finish;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#2000000;
		failures++;
		tally_and_finish;
	end

	initial begin
		logic [31:0] r;
		logic        e;
		logic [7:0]  tx;
		int          n;
		logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h8, 32'h0, 32'h0, 32'h0, 32'h3};
		int          ps [4] = '{1, 2, 8, 32};
		void'($urandom(32'h7e5fe2e4));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rd(12'(4 * i), r);
			`CHK(r, rv[i])
		end
		apb(1'b0, 12'h020, 32'h0, r, e);
		`CHK({e, r}, 33'h100000000)
		// Each prescaler once, with LSB-first, polarity 1 and inversion mixed in
		for (int i = 0; i < 4; i++) begin
			n = $urandom % 3;
			wr(`DIVIDER_ADDR, n);
			wr(`CTRL_ZERO_ADDR, {(i != 1), (i == 2), 3'b010, 2'(i)});
			wr(`CTRL_ONE_ADDR, {(i == 3), 4'h3});
			pol <= (i == 2);
			pw <= 8'($urandom);
			tx = 8'($urandom);
			repeat (4) @(posedge clk);
			ld <= ~ld;
			{ntx, nrx, nact} = 0;
			wr(`TX_BUF_ADDR, tx);
			wt(nrx, 1);
			`CHK(nact, 8 * (n + 1) * ps[i])
			`CHK(ntx, 1)
			`CHK(got, expb(tx, i != 1, i == 3))
			rd(`RX_BUF_ADDR, r);
			`CHK(r[7:0], expb(pw, i != 1, i == 3))
		end
		wr(`DIVIDER_ADDR, 32'h0);
		wr(`CTRL_ZERO_ADDR, 32'h48);
		wr(`CTRL_ONE_ADDR, 32'h07);
		pol <= 1'b0;
		{ntx, nrx, nact} = 0;
		wr(`TX_BUF_ADDR, 32'h5a);
		wt(ntx, 1);
		`CHK(nact, 8)
		wr(`TX_BUF_ADDR, 32'ha5);
		wt(ntx, 2);
		repeat (3) @(posedge clk);
		`CHK(nrx, 1)
		rd(`STATUS_ADDR, r);
		`CHK(r[3], 1'b1)
		wr(`CTRL_ONE_ADDR, 32'h0b);
		nrx = 0;
		rd(`RX_BUF_ADDR, r);
		wt(nrx, 1);
		`CHK(nrx, 1)
		wr(`CTRL_ZERO_ADDR, 32'h40);
		wr(`CTRL_ONE_ADDR, 32'h02);
		rd(`RX_BUF_ADDR, r);
		{ntx, nrx, nact} = 0;
		wr(`TX_BUF_ADDR, 32'h3c);
		repeat (40) @(posedge clk);
		`CHK(nact, 0)
		wr(`CTRL_ONE_ADDR, 32'h03);
		repeat (40) @(posedge clk);
		`CHK(nact, 0)
		cts <= 1'b0;
		wt(nrx, 1);
		`CHK(nact, 8)
		// External transfer clock from the pin, slow against clk
		rd(`RX_BUF_ADDR, r);
		wr(`MODE_REG_ADDR, 32'h1);
		wr(`CTRL_ZERO_ADDR, 32'h48);
		ext <= 1'b1;
		pw <= 8'($urandom);
		tx = 8'($urandom);
		repeat (2) @(posedge clk);
		ld <= ~ld;
		{ntx, nrx, nact} = 0;
		wr(`TX_BUF_ADDR, tx);
		repeat (16) begin
			repeat (4) @(posedge clk);
			esck <= ~esck;
		end
		wt(nrx, 1);
		`CHK(got, tx)
		`CHK(nact, 0)
		rd(`RX_BUF_ADDR, r);
		`CHK(r[7:0], pw)
		tally_and_finish;
	end
endmodule
